/* File: design/accumulator_saturate_round.sv */
`timescale 1ns/100ps

module accumulator_saturate_round #(
	parameter int ACC_W  = 40,
	parameter int WORD_W = 16,
	parameter int ADDR_W = 16
) (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Saturation configuration from the core
	input  wire logic                 sat_enable,
	input  wire logic                 sat_bit31_sel,
	// Decoded operation
	input  wire logic                 op_valid,
	input  acc_pkg::op_code_type      op_code,
	input  wire logic                 op_target,
	input  wire logic [ACC_W-1:0]     op_operand,
	input  acc_pkg::wb_mode_type      op_wb_mode,
	input  wire logic [ADDR_W-1:0]    op_addr,
	// X bus write port
	output logic                      xbus_wr,
	output logic      [ADDR_W-1:0]    xbus_addr,
	output logic      [WORD_W-1:0]    xbus_wdata,
	// Status and trap
	output logic                      first_acc_clip_flag,
	output logic                      second_acc_clip_flag,
	output logic                      first_acc_guard_overflow,
	output logic                      second_acc_guard_overflow,
	output logic                      any_guard_overflow,
	output logic                      any_clip_flag,
	output logic                      trap_req
);

	// ==================================================================
	// State
	logic [ACC_W-1:0]  acc_r [2];
	logic [1:0]        clip_r;
	logic [1:0]        guard_r;
	logic              round_kind_select_r;
	logic              wrap_trap_enable_r;
	logic [ADDR_W-1:0] writeback_pointer_reg_r;
	logic [31:0]       prdata_r;
	logic              xbus_wr_r;
	logic [ADDR_W-1:0] xbus_addr_r;
	logic [WORD_W-1:0] xbus_wdata_r;

	// ==================================================================
	// Combinational datapath signals
	acc_pkg::sat_mode_type sat_mode;
	acc_pkg::reg_sel_type  sel;
	logic                  arith_op;
	logic                  accumulate;
	logic                  negate;
	logic [ACC_W-1:0]      tgt_acc;
	logic [ACC_W-1:0]      other_acc;
	logic [ACC_W:0]        addend_a;
	logic [ACC_W:0]        addend_b;
	logic [ACC_W:0]        sum_full;
	logic [ACC_W-1:0]      wrapped;
	logic                  ovf39;
	logic                  ovf31;
	logic                  positive;
	logic [ACC_W-1:0]      result;
	logic                  clip_set;
	logic                  guard_set;
	logic                  wb_allowed;
	logic                  wb_direct;
	logic                  wb_post_inc;
	logic                  store_op;
	logic [ACC_W-1:0]      round_src;
	logic                  round_en;
	logic [WORD_W-1:0]     rounded_word;
	logic                  apb_setup;
	logic                  apb_write;
	logic [1:0]            clip_clr;

	// ==================================================================
	// Register address decode, shared by reads, writes and errors
	function automatic acc_pkg::reg_sel_type decode(
		input logic [7:0] addr
	);
		case (addr)
			acc_pkg::CORE_CTRL_OFS: decode = acc_pkg::REG_CORE;
			acc_pkg::TRAP_CTRL_OFS: decode = acc_pkg::REG_TRAP;
			acc_pkg::STATUS_OFS:    decode = acc_pkg::REG_STATUS;
			acc_pkg::WB_PTR_OFS:    decode = acc_pkg::REG_PTR;
			acc_pkg::ACCA_LO_OFS:   decode = acc_pkg::REG_ACCA_LO;
			acc_pkg::ACCA_HI_OFS:   decode = acc_pkg::REG_ACCA_HI;
			acc_pkg::ACCB_LO_OFS:   decode = acc_pkg::REG_ACCB_LO;
			acc_pkg::ACCB_HI_OFS:   decode = acc_pkg::REG_ACCB_HI;
			default:                decode = acc_pkg::REG_NONE;
		endcase
	endfunction : decode

	// ==================================================================
	// Overflow mode from the configuration pins
	// Core holds these steady while accumulator ops run
	always_comb begin
		if (!sat_enable) begin
			sat_mode = acc_pkg::MODE_WRAP;
		end else if (sat_bit31_sel) begin
			sat_mode = acc_pkg::MODE_SAT31;
		end else begin
			sat_mode = acc_pkg::MODE_SAT39;
		end
	end

	// ==================================================================
	// Adder/subtracter with one extra bit to see the true sign
	always_comb begin
		tgt_acc    = acc_r[op_target];
		other_acc  = acc_r[~op_target];
		arith_op   = op_valid && !(op_code inside {acc_pkg::STORE_ACC_OP,
			acc_pkg::STORE_ACC_ROUNDED_OP});
		accumulate = op_code inside {acc_pkg::MAC_OP, acc_pkg::MSUB_OP,
			acc_pkg::EUCLID_DIST_ACCUM_OP};
		negate     = (op_code == acc_pkg::MSUB_OP)
			|| (op_code == acc_pkg::NEGATED_MULTIPLY_OP);
		addend_a   = accumulate ? {tgt_acc[ACC_W-1], tgt_acc} : '0;
		addend_b   = {op_operand[ACC_W-1], op_operand};
		if (negate) begin
			addend_b = (ACC_W+1)'(~addend_b + 1'b1);
		end
		sum_full   = (ACC_W+1)'(addend_a + addend_b);
		wrapped    = sum_full[ACC_W-1:0];
		positive   = ~sum_full[ACC_W];
		// Bit 39 overflow: true sign differs from stored sign
		ovf39      = sum_full[ACC_W] ^ sum_full[ACC_W-1];
		// Bit 31 overflow: value no longer fits a 1.31 number
		ovf31      = ovf39 || (wrapped[ACC_W-1:31] != {(ACC_W-31){wrapped[31]}});
	end

	// ==================================================================
	// Saturation and flag events for the target accumulator
	always_comb begin
		result    = wrapped;
		clip_set  = 1'b0;
		guard_set = 1'b0;
		case (sat_mode)
			acc_pkg::MODE_SAT39: begin
				clip_set = ovf39;
				if (ovf39) begin
					result = positive ? acc_pkg::SAT39_POS : acc_pkg::SAT39_NEG;
				end
			end
			acc_pkg::MODE_SAT31: begin
				clip_set = ovf31;
				if (ovf31) begin
					result = positive ? acc_pkg::SAT31_POS : acc_pkg::SAT31_NEG;
				end
			end
			default: begin
				// Wrap: sign is lost, only the flag records it
				clip_set = ovf39;
			end
		endcase
		// Guard bits in use once bits 39..31 disagree
		if (sat_mode != acc_pkg::MODE_SAT31) begin
			guard_set = result[ACC_W-1:31] != {(ACC_W-31){result[31]}};
		end
	end

	// ==================================================================
	// Write-back and store selection
	always_comb begin
		wb_allowed  = op_valid
			&& (op_code inside {acc_pkg::MAC_OP, acc_pkg::MSUB_OP});
		wb_direct   = wb_allowed && (op_wb_mode == acc_pkg::WB_REG_DIRECT);
		wb_post_inc = wb_allowed && (op_wb_mode == acc_pkg::WB_POST_INC);
		store_op    = op_valid && (op_code inside {acc_pkg::STORE_ACC_OP,
			acc_pkg::STORE_ACC_ROUNDED_OP});
		// Write-back reads the other accumulator before this op lands
		round_src   = store_op ? tgt_acc : other_acc;
		round_en    = store_op
			? (op_code == acc_pkg::STORE_ACC_ROUNDED_OP)
			: 1'b1;
	end

	// Shared round unit; store and write-back never coincide
	round_unit #(
		.ACC_W      (ACC_W)
	) u_round (
		.acc_in     (round_src),
		.round_en   (round_en),
		.convergent (round_kind_select_r),
		.word_out   (rounded_word)
	);

	// ==================================================================
	// Accumulators and per-accumulator flags
	generate
		for (genvar g = 0; g < 2; g++) begin : g_acc
			logic hit;
			assign hit = arith_op && (op_target == 1'(g));

			// Only the target accumulator takes the result
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					acc_r[g] <= acc_pkg::ACC_RESET;
				end else if (hit) begin
					acc_r[g] <= result;
				end
			end

			// Sticky clip: set beats a same-cycle software clear
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					clip_r[g] <= 1'b0;
				end else begin
					clip_r[g] <= (clip_r[g] & ~clip_clr[g])
						| (hit & clip_set);
				end
			end

			// Guard overflow reflects the latest result only
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					guard_r[g] <= 1'b0;
				end else if (sat_mode == acc_pkg::MODE_SAT31) begin
					guard_r[g] <= 1'b0;
				end else if (hit) begin
					guard_r[g] <= guard_set;
				end
			end
		end
	endgenerate

	// ==================================================================
	// APB decode; every access completes without wait states
	always_comb begin
		sel       = decode(paddr);
		apb_setup = psel && !penable;
		apb_write = psel && penable && pwrite
			&& (sel != acc_pkg::REG_NONE);
		clip_clr  = 2'b00;
		if (apb_write && (sel == acc_pkg::REG_STATUS) && pstrb[0]) begin
			clip_clr = {pwdata[acc_pkg::ST_CLIP_B],
				pwdata[acc_pkg::ST_CLIP_A]};
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && (sel == acc_pkg::REG_NONE);
	assign prdata  = prdata_r;

	// Control bits steering rounding and trapping
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			round_kind_select_r <= 1'b0;
			wrap_trap_enable_r  <= 1'b0;
		end else if (apb_write && pstrb[0]) begin
			if (sel == acc_pkg::REG_CORE) begin
				round_kind_select_r <= pwdata[acc_pkg::ROUND_KIND_BIT];
			end
			if (sel == acc_pkg::REG_TRAP) begin
				wrap_trap_enable_r <= pwdata[acc_pkg::WRAP_TRAP_BIT];
			end
		end
	end

	// Pointer: hardware write-back wins over a software write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			writeback_pointer_reg_r <= acc_pkg::PTR_RESET;
		end else if (wb_direct) begin
			writeback_pointer_reg_r <= rounded_word;
		end else if (wb_post_inc) begin
			writeback_pointer_reg_r <= writeback_pointer_reg_r
				+ acc_pkg::PTR_STEP;
		end else if (apb_write && (sel == acc_pkg::REG_PTR)) begin
			if (pstrb[0]) begin
				writeback_pointer_reg_r[7:0] <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				writeback_pointer_reg_r[15:8] <= pwdata[15:8];
			end
		end
	end

	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_r <= 32'h00000000;
		end else if (apb_setup && !pwrite) begin
			case (sel)
				acc_pkg::REG_CORE: prdata_r <= {31'h00000000, round_kind_select_r};
				acc_pkg::REG_TRAP: prdata_r <= {31'h00000000, wrap_trap_enable_r};
				acc_pkg::REG_STATUS:
					prdata_r <= {25'h0000000, trap_req,
						any_clip_flag, any_guard_overflow,
						guard_r, clip_r};
				acc_pkg::REG_PTR: prdata_r <= {16'h0000, writeback_pointer_reg_r};
				acc_pkg::REG_ACCA_LO: prdata_r <= acc_r[0][31:0];
				acc_pkg::REG_ACCA_HI: prdata_r <= {24'h000000, acc_r[0][39:32]};
				acc_pkg::REG_ACCB_LO: prdata_r <= acc_r[1][31:0];
				acc_pkg::REG_ACCB_HI: prdata_r <= {24'h000000, acc_r[1][39:32]};
				default: prdata_r <= 32'h00000000;
			endcase
		end
	end

	// ==================================================================
	// X bus write: stores and post-increment write-back
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xbus_wr_r    <= 1'b0;
			xbus_addr_r  <= '0;
			xbus_wdata_r <= '0;
		end else begin
			xbus_wr_r <= store_op || wb_post_inc;
			if (store_op) begin
				xbus_addr_r  <= op_addr;
				xbus_wdata_r <= rounded_word;
			end else if (wb_post_inc) begin
				xbus_addr_r  <= writeback_pointer_reg_r;
				xbus_wdata_r <= rounded_word;
			end
		end
	end

	assign xbus_wr    = xbus_wr_r;
	assign xbus_addr  = xbus_addr_r;
	assign xbus_wdata = xbus_wdata_r;

	// ==================================================================
	// Status outputs and trap request
	assign first_acc_clip_flag       = clip_r[0];
	assign second_acc_clip_flag      = clip_r[1];
	assign first_acc_guard_overflow  = guard_r[0];
	assign second_acc_guard_overflow = guard_r[1];
	assign any_guard_overflow        = |guard_r;
	assign any_clip_flag             = |clip_r;
	// Level request; it drops once software clears the clip flags
	assign trap_req = wrap_trap_enable_r && !sat_enable
		&& (|clip_r);

endmodule : accumulator_saturate_round

/* File: design/acc_pkg.sv */
package acc_pkg;

	// ==================================================================
	// Datapath widths and constants
	localparam int ACC_W  = 40;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 16;
	localparam logic [39:0] SAT39_POS = 40'h7FFFFFFFFF;
	localparam logic [39:0] SAT39_NEG = 40'h8000000000;
	localparam logic [39:0] SAT31_POS = 40'h007FFFFFFF;
	localparam logic [39:0] SAT31_NEG = 40'hFF80000000;
	localparam logic [15:0] ROUND_HALF   = 16'h8000;
	localparam logic [15:0] PTR_STEP     = 16'h0002;
	localparam logic [15:0] PTR_RESET    = 16'h0000;
	localparam logic [39:0] ACC_RESET    = 40'h0000000000;

	// ==================================================================
	// Register byte offsets
	localparam logic [7:0] CORE_CTRL_OFS = 8'h00;
	localparam logic [7:0] TRAP_CTRL_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS    = 8'h08;
	localparam logic [7:0] WB_PTR_OFS    = 8'h0C;
	localparam logic [7:0] ACCA_LO_OFS   = 8'h10;
	localparam logic [7:0] ACCA_HI_OFS   = 8'h14;
	localparam logic [7:0] ACCB_LO_OFS   = 8'h18;
	localparam logic [7:0] ACCB_HI_OFS   = 8'h1C;

	// ==================================================================
	// Field positions
	localparam int ROUND_KIND_BIT = 0;
	localparam int WRAP_TRAP_BIT  = 0;
	localparam int ST_CLIP_A      = 0;
	localparam int ST_CLIP_B      = 1;
	localparam int ST_GUARD_A     = 2;
	localparam int ST_GUARD_B     = 3;
	localparam int ST_ANY_GUARD   = 4;
	localparam int ST_ANY_CLIP    = 5;
	localparam int ST_TRAP        = 6;

	// ==================================================================
	// Enumerations
	typedef enum logic [2:0] {
		MAC_OP,
		MSUB_OP,
		PLAIN_MULTIPLY_OP,
		NEGATED_MULTIPLY_OP,
		EUCLID_DIST_OP,
		EUCLID_DIST_ACCUM_OP,
		STORE_ACC_OP,
		STORE_ACC_ROUNDED_OP
	} op_code_type;

	typedef enum logic [1:0] {
		WB_NONE,
		WB_REG_DIRECT,
		WB_POST_INC
	} wb_mode_type;

	typedef enum logic [1:0] {
		MODE_WRAP,
		MODE_SAT39,
		MODE_SAT31
	} sat_mode_type;

	typedef enum logic [3:0] {
		REG_CORE, REG_TRAP, REG_STATUS, REG_PTR,
		REG_ACCA_LO, REG_ACCA_HI, REG_ACCB_LO, REG_ACCB_HI,
		REG_NONE
	} reg_sel_type;

endpackage : acc_pkg

/* File: design/round_unit.sv */
`timescale 1ns/100ps

// ======================================================================
// Combinational round of an accumulator to a 1.15 word
module round_unit #(
	parameter int ACC_W = 40
) (
	input  wire logic [ACC_W-1:0] acc_in,
	input  wire logic             round_en,
	input  wire logic             convergent,
	output logic      [15:0]      word_out
);

	logic [15:0] low_word;
	logic [15:0] high_word;
	logic        tie;
	logic        inc;

	// Low word picks the increment; a tie defers to bit 16 if convergent
	always_comb begin
		low_word  = acc_in[15:0];
		high_word = acc_in[31:16];
		tie       = (low_word == acc_pkg::ROUND_HALF);
		inc       = round_en && low_word[15];
		if (convergent && tie) begin
			inc = round_en && high_word[0];
		end
		// Without rounding the low word is simply dropped
		word_out = high_word + {15'h0000, inc};
	end

endmodule : round_unit

/* File: dv/xbus_data_space.sv */
`timescale 1ns/100ps

// ==================================================
// Data space behind the X bus write port
module xbus_data_space (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        xbus_wr,
	input wire logic [15:0] xbus_addr,
	input wire logic [15:0] xbus_wdata
);
	logic [15:0] mem [65536];
	int          wr_cnt;

	// One word per strobe; the count exposes stray writes
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_cnt <= 0;
		end else if (xbus_wr) begin
			mem[xbus_addr] <= xbus_wdata;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule : xbus_data_space

/* File: dv/accumulator_saturate_round_properties.sv */
`timescale 1ns/100ps

// ==================================================
// Port checks of the accumulator back-end
module acc_sat_round_checker (
	input wire logic            clk,
	input wire logic            nrst,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [7:0]      paddr,
	input wire logic [31:0]     pwdata,
	input wire logic            sat_enable,
	input wire logic            sat_bit31_sel,
	input wire logic            op_valid,
	input acc_pkg::op_code_type op_code,
	input acc_pkg::wb_mode_type op_wb_mode,
	input wire logic [15:0]     op_addr,
	input wire logic            xbus_wr,
	input wire logic [15:0]     xbus_addr,
	input wire logic            first_acc_clip_flag,
	input wire logic            second_acc_clip_flag,
	input wire logic            first_acc_guard_overflow,
	input wire logic            second_acc_guard_overflow,
	input wire logic            any_guard_overflow,
	input wire logic            any_clip_flag,
	input wire logic            trap_req
);
	// Status write strobe, the only thing allowed to lower a clip flag
	logic clr_hit;
	assign clr_hit = psel && penable && pwrite && paddr == acc_pkg::STATUS_OFS;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	clip_a_sticky_a:
		assert property ($fell(first_acc_clip_flag) |-> $past(clr_hit && pwdata[0]))
		else $error("first clip flag fell without a clear");
	clip_b_sticky_a:
		assert property ($fell(second_acc_clip_flag) |-> $past(clr_hit && pwdata[1]))
		else $error("second clip flag fell without a clear");
	any_clip_or_a:
		assert property (any_clip_flag == (first_acc_clip_flag || second_acc_clip_flag))
		else $error("combined clip status wrong");
	any_guard_or_a:
		assert property (any_guard_overflow ==
			(first_acc_guard_overflow || second_acc_guard_overflow))
		else $error("combined guard status wrong");
	guard_31_off_a:
		assert property (sat_enable && sat_bit31_sel |=>
			!first_acc_guard_overflow && !second_acc_guard_overflow)
		else $error("guard flag set in bit 31 mode");
	trap_cause_a:
		assert property (trap_req |-> !sat_enable && any_clip_flag)
		else $error("trap request without wrap overflow");
	store_write_a:
		assert property (op_valid && op_code inside {acc_pkg::STORE_ACC_OP,
			acc_pkg::STORE_ACC_ROUNDED_OP} |=> xbus_wr && xbus_addr == $past(op_addr))
		else $error("store did not reach the X bus");
	post_inc_wb_a:
		assert property (op_valid && op_code inside {acc_pkg::MAC_OP, acc_pkg::MSUB_OP}
			&& op_wb_mode == acc_pkg::WB_POST_INC |=> xbus_wr)
		else $error("post-increment write-back missing");
	excluded_wb_a:
		assert property (op_valid && op_code inside {[acc_pkg::PLAIN_MULTIPLY_OP:
			acc_pkg::EUCLID_DIST_ACCUM_OP]} |=> !xbus_wr)
		else $error("excluded operation wrote back");
	direct_wb_a:
		assert property (op_valid && op_code inside {acc_pkg::MAC_OP, acc_pkg::MSUB_OP}
			&& op_wb_mode != acc_pkg::WB_POST_INC |=> !xbus_wr)
		else $error("bus write without post-increment mode");
	xbus_cause_a:
		assert property (xbus_wr |-> $past(op_valid))
		else $error("X bus write without an operation");

	cover property (trap_req);
	cover property ($rose(second_acc_clip_flag));
	cover property (op_valid && op_code == acc_pkg::STORE_ACC_ROUNDED_OP ##1 xbus_wr);
endmodule : acc_sat_round_checker

bind accumulator_saturate_round acc_sat_round_checker props (.clk, .nrst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .sat_enable, .sat_bit31_sel,
	.op_valid, .op_code, .op_wb_mode, .op_addr, .xbus_wr, .xbus_addr,
	.first_acc_clip_flag, .second_acc_clip_flag, .first_acc_guard_overflow,
	.second_acc_guard_overflow, .any_guard_overflow, .any_clip_flag, .trap_req);

/* File: dv/accumulator_saturate_round_tb_top.sv */
`timescale 1ns/100ps

// ==================================================
// Bench top: APB master, operation driver, reference model
module accumulator_saturate_round_tb_top;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, rd;
	logic [3:0] pstrb = 4'hF;
	logic sat_enable = 1'b0, sat_bit31_sel = 1'b0, op_valid = 1'b0;
	logic op_target = 1'b0, err, conv_m = 1'b0, trap_en_m = 1'b0;
	acc_pkg::op_code_type op_code = acc_pkg::MAC_OP;
	acc_pkg::wb_mode_type op_wb_mode = acc_pkg::WB_NONE;
	logic [39:0] op_operand = '0, top;
	logic [15:0] op_addr = '0, seed = 16'h0006, ptr_m = 16'h0000;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, xbus_wr, first_acc_clip_flag, trap_req;
	wire logic second_acc_clip_flag, any_guard_overflow, any_clip_flag;
	wire logic first_acc_guard_overflow, second_acc_guard_overflow;
	wire logic [15:0] xbus_addr, xbus_wdata;
	int n_fail = 0, checks_done = 0, cyc = 0;
	logic [39:0] acc_m [2] = '{2{40'h0000000000}};
	logic clip_m [2] = '{2{1'b0}}, g_m [2] = '{2{1'b0}};
	logic [39:0] rv [4] = '{40'h0000017FFF, 40'h0000018000, 40'h0000028000,
		40'h0000028001};

	accumulator_saturate_round dut (.clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sat_enable,
		.sat_bit31_sel, .op_valid, .op_code, .op_target, .op_operand,
		.op_wb_mode, .op_addr, .xbus_wr, .xbus_addr, .xbus_wdata,
		.first_acc_clip_flag, .second_acc_clip_flag, .first_acc_guard_overflow,
		.second_acc_guard_overflow, .any_guard_overflow, .any_clip_flag, .trap_req);
	xbus_data_space xmem (.clk, .nrst, .xbus_wr, .xbus_addr, .xbus_wdata);

	// Clock and hang guard, the whole run needs well under 5000 cycles
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end

	// ==================================================
	// Helpers
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Half-way case alone separates the two round kinds
	function automatic logic [15:0] rnd(logic [39:0] a, logic en, logic cv);
		if (en && (a[15:0] > 16'h8000 || (a[15:0] == 16'h8000 && (!cv || a[16]))))
			return a[31:16] + 16'h0001;
		return a[31:16];
	endfunction : rnd
	function automatic logic [6:0] st_exp();
		logic c;
		c = clip_m[0] | clip_m[1];
		return {trap_en_m & ~sat_enable & c, c, g_m[0] | g_m[1], g_m[1], g_m[0],
			clip_m[1], clip_m[0]};
	endfunction : st_exp
	task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// One APB transfer, held until pready is seen high
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Model one operation, issue it, then compare bus, flags and accumulator
	task automatic run_op(acc_pkg::op_code_type c, logic t, logic [39:0] v,
		acc_pkg::wb_mode_type wb);
		logic signed [40:0] s;
		logic ov, wr, mac;
		logic [15:0] wa, wd;
		logic [31:0] lo;
		int n;
		n = xmem.wr_cnt;
		wr = 1'b0;
		wa = ptr_m;
		wd = rnd(acc_m[!t], 1'b1, conv_m);
		mac = c inside {acc_pkg::MAC_OP, acc_pkg::MSUB_OP};
		s = {acc_m[t][39], acc_m[t]};
		case (c)
			acc_pkg::MAC_OP, acc_pkg::EUCLID_DIST_ACCUM_OP: s = s + {v[39], v};
			acc_pkg::MSUB_OP: s = s - {v[39], v};
			acc_pkg::NEGATED_MULTIPLY_OP: s = -{v[39], v};
			acc_pkg::PLAIN_MULTIPLY_OP, acc_pkg::EUCLID_DIST_OP: s = {v[39], v};
			default: begin
				wr = 1'b1;
				wa = seed;
				wd = rnd(acc_m[t], c == acc_pkg::STORE_ACC_ROUNDED_OP, conv_m);
			end
		endcase
		if (!wr) begin
			ov = (sat_enable && sat_bit31_sel) ? !(&s[40:31] || ~|s[40:31])
				: s[40] != s[39];
			acc_m[t] = s[39:0];
			if (ov && sat_enable && sat_bit31_sel)
				acc_m[t] = s[40] ? acc_pkg::SAT31_NEG : acc_pkg::SAT31_POS;
			else if (ov && sat_enable)
				acc_m[t] = s[40] ? acc_pkg::SAT39_NEG : acc_pkg::SAT39_POS;
			clip_m[t] |= ov;
			g_m[t] = !(&acc_m[t][39:31] || ~|acc_m[t][39:31]);
			wr = mac && wb == acc_pkg::WB_POST_INC;
			if (wr) ptr_m += acc_pkg::PTR_STEP;
			if (mac && wb == acc_pkg::WB_REG_DIRECT) ptr_m = wd;
		end
		if (sat_enable && sat_bit31_sel) g_m = '{2{1'b0}};
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_target <= t;
		op_operand <= v;
		op_wb_mode <= wb;
		op_addr <= seed;
		@(posedge clk);
		op_valid <= 1'b0;
		@(posedge clk);
		#1;
		chk("xbus writes", xmem.wr_cnt, n + wr);
		if (wr) chk("xbus addr", xbus_addr, wa);
		if (wr) chk("xbus data", xmem.mem[wa], wd);
		chk("flags", {trap_req, any_clip_flag, any_guard_overflow,
			second_acc_guard_overflow, first_acc_guard_overflow,
			second_acc_clip_flag, first_acc_clip_flag}, st_exp());
		apb(1'b0, t ? acc_pkg::ACCB_LO_OFS : acc_pkg::ACCA_LO_OFS, '0);
		lo = rd;
		apb(1'b0, t ? acc_pkg::ACCB_HI_OFS : acc_pkg::ACCA_HI_OFS, '0);
		chk("accumulator", {rd[7:0], lo}, acc_m[t]);
	endtask : run_op

	// ==================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, acc_pkg::STATUS_OFS, '0);
		chk("status reset", rd, '0);
		apb(1'b1, 8'h40, 32'hFFFFFFFF);
		chk("unmapped write", err, 1'b1);
		apb(1'b0, 8'h40, '0);
		chk("unmapped read", {err, rd}, {1'b1, 32'h00000000});
		apb(1'b1, acc_pkg::TRAP_CTRL_OFS, 32'h00000001);
		trap_en_m = 1'b1;
		apb(1'b0, acc_pkg::TRAP_CTRL_OFS, '0);
		chk("trap enable", rd, 32'h00000001);
		// Both round kinds over the boundary low words and a random one
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, acc_pkg::CORE_CTRL_OFS, 32'(k));
			conv_m = k[0];
			apb(1'b0, acc_pkg::CORE_CTRL_OFS, '0);
			chk("round kind", rd, 32'(k));
			for (int i = 0; i < 5; i++) begin
				seed = lfsr(seed);
				top = (i == 4) ? {9'h000, seed[14:0], seed} : rv[i % 4];
				run_op(acc_pkg::PLAIN_MULTIPLY_OP, 1'b0, top, acc_pkg::WB_NONE);
				run_op(acc_pkg::STORE_ACC_OP, 1'b0, '0, acc_pkg::WB_NONE);
				seed = lfsr(seed);
				run_op(acc_pkg::STORE_ACC_ROUNDED_OP, 1'b0, '0, acc_pkg::WB_NONE);
			end
		end
		// Wrap, bit 39 and bit 31 modes, overflow both ways
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			sat_enable <= m != 0;
			sat_bit31_sel <= m == 2;
			apb(1'b1, acc_pkg::STATUS_OFS, 32'h00000003);
			clip_m = '{2{1'b0}};
			top = (m == 2) ? acc_pkg::SAT31_POS : acc_pkg::SAT39_POS;
			run_op(acc_pkg::PLAIN_MULTIPLY_OP, 1'b1, top, acc_pkg::WB_NONE);
			run_op(acc_pkg::MAC_OP, 1'b1, 40'h0000000001, acc_pkg::WB_NONE);
			run_op(acc_pkg::PLAIN_MULTIPLY_OP, 1'b0, ~top, acc_pkg::WB_NONE);
			run_op(acc_pkg::MSUB_OP, 1'b0, 40'h0000000001, acc_pkg::WB_NONE);
			apb(1'b0, acc_pkg::STATUS_OFS, '0);
			chk("status", rd, {25'h0000000, st_exp()});
		end
		// Write-back of the other accumulator, excluded ops in between
		@(posedge clk);
		sat_enable <= 1'b0;
		sat_bit31_sel <= 1'b0;
		apb(1'b1, acc_pkg::WB_PTR_OFS, 32'h00000100);
		ptr_m = 16'h0100;
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			run_op(acc_pkg::op_code_type'(2 + i % 4), i[0],
				{9'h000, seed[14:0], seed}, acc_pkg::WB_POST_INC);
			run_op(i < 3 ? acc_pkg::MAC_OP : acc_pkg::MSUB_OP, !i[0], {24'h000000, seed},
				i == 5 ? acc_pkg::WB_REG_DIRECT : acc_pkg::WB_POST_INC);
		end
		apb(1'b0, acc_pkg::WB_PTR_OFS, '0);
		chk("pointer", rd[15:0], ptr_m);
		results();
	end
endmodule : accumulator_saturate_round_tb_top
